/* hw/psd_regs.svh */
// Offsets, field positions, reset values and timing for the strap, PRBS
// counter and RGMII delay register group. Assumes a 32-bit APB slave.
`ifndef PSD_REGS_SVH
`define PSD_REGS_SVH
// Register indices; byte address is four times the index
`define PSD_IDX_FASTDV 10'h043
`define PSD_IDX_MODE 10'h016
`define PSD_IDX_STRAP 10'h06E
`define PSD_IDX_BYTE 10'h071
`define PSD_IDX_ERR 10'h072
`define PSD_IDX_PKTLEN 10'h07B
`define PSD_IDX_DLL 10'h086
`define PSD_IDX_PLL 10'h0C6
// Field positions
`define PSD_ERR_LOCK 0
`define PSD_ERR_CLR 1
`define PSD_ERR_BOVF 9
`define PSD_ERR_POVF 10
`define PSD_DLL_FVAL 9
`define PSD_DLL_FCTRL 8
`define PSD_MODE_CONT 0
`define PSD_MODE_SHIFT 1
// Reset values, limits and the align delay code
`define PSD_RST_PKTLEN 16'h05DC
`define PSD_RST_DLL 10'h077
`define PSD_RST_MODE 2'h2
`define PSD_BYTE_MAX 16'hFFFF
`define PSD_ERR_MAX 16'h00FF
`define PSD_ALIGN_CODE 4'hF
// Delay step in picoseconds
`define PSD_STEP_PS 250
`endif

/* hw/psd_pkg.sv */
// Types for the strap, PRBS counter and RGMII delay register group.
// Assumes psd_regs.svh is on the include path.
package psd_pkg;
  // Latched bootstrap levels, ordered as the status bits 13..0
  typedef struct packed {
    logic linkloss_passthrough_boot;
    logic mirror_boot;
    logic [2:0] operating_mode_boot;
    logic [4:0] phy_address_boot;
    logic [1:0] autoneg_select_boot;
    logic autoneg_enable_boot;
    logic mac_mii_boot;
  } psd_strap_t;
  // One-cycle events from the PRBS checker
  typedef struct packed {
    logic byte_rx;
    logic byte_err;
    logic pkt_done;
  } psd_chk_evt_t;
  // Applied delay line settings
  typedef struct packed {
    logic dll_en;
    logic [4:0] tx_steps;
    logic [4:0] rx_steps;
  } psd_dly_t;
  // Whole state of the block
  typedef struct packed {
    psd_strap_t strap_s1;
    psd_strap_t strap_s2;
    psd_strap_t strap;
    logic strap_taken;
    logic [15:0] byte_cnt;
    logic [7:0] err_cnt;
    logic [15:0] pkt_cnt;
    logic [15:0] byte_vis;
    logic [7:0] err_vis;
    logic pkt_ovf;
    logic byte_ovf;
    logic [15:0] pkt_len;
    logic [9:0] dll_ctrl;
    logic [15:0] pll;
    logic fast_dv;
    logic [1:0] mode;
    logic [15:0] rdata;
    psd_dly_t dly;
  } psd_state_t;
endpackage

/* hw/psd_top.sv */
// Strap status, PRBS counters, packet length and RGMII delay registers.
// Assumes an APB master on REF_CLK_I and checker events on the same clock.
`timescale 1ns/10ps
`include "psd_regs.svh"
module psd_top (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Bootstrap pins, asynchronous
  input wire psd_pkg::psd_strap_t STRAP_I,
  // PRBS checker events and automatic DLL enable
  input wire psd_pkg::psd_chk_evt_t CHK_EVT_I,
  input wire logic DLL_AUTO_EN_I,
  // Settings toward the datapath
  output psd_pkg::psd_strap_t STRAP_O,
  output logic [15:0] TEST_PACKET_LENGTH_O,
  output psd_pkg::psd_dly_t DLY_O,
  output logic [15:0] PLL_PHASE_SETTING_O,
  output logic EARLY_RECEIVE_VALID_O,
  output logic CNT_CONTINUOUS_O
);
  import psd_pkg::*;

  // Saturating or wrapping increment; top bit flags overflow
  function automatic logic [16:0] step(input logic [15:0] c,
                                       input logic [15:0] mx,
                                       input logic inc,
                                       input logic cont);
    logic [16:0] r;
    r = {1'b0, c};
    if (inc && c == mx) begin
      r = {1'b1, cont ? 16'h0000 : mx};
    end else if (inc) begin
      r = {1'b0, c + 16'h0001};
    end
    return r;
  endfunction

  // Delay code to 250 ps steps; zero in align mode
  function automatic logic [4:0] dsteps(input logic [3:0] code,
                                        input logic shift);
    logic [4:0] r;
    r = 5'h00;
    if (shift && code != `PSD_ALIGN_CODE) begin
      r = {1'b0, code} + 5'h01;
    end
    return r;
  endfunction

  // Byte-lane merge for the low halfword
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [1:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      r[15:8] = nw[15:8];
    end
    return r;
  endfunction

  psd_state_t state_q; // Registered state
  psd_state_t state_d; // Next state
  logic [9:0] idx; // Word index
  logic hit; // Address maps to a register
  logic [15:0] rmux; // Read value of addressed register
  logic acc; // Access phase
  logic wr; // Write takes effect
  logic lock; // Snapshot request
  logic clr; // Snapshot and clear request
  logic [16:0] byte_nx; // Byte counter step
  logic [16:0] err_nx; // Error counter step
  logic [16:0] pkt_nx; // Packet counter step
  logic [15:0] wdat; // Written halfword
  logic cont; // Continuous count mode

  assign idx = PADDR_I[11:2];
  assign acc = PSEL_I & PENABLE_I;
  assign wdat = PWDATA_I[15:0];
  assign cont = state_q.mode[`PSD_MODE_CONT];
  // No wait states; the read word was prepared in the setup cycle
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc & ~hit;
  assign wr = acc & PWRITE_I & hit;
  // Writing a one to either trigger bit, low byte lane enabled
  assign lock = wr && idx == `PSD_IDX_ERR && PSTRB_I[0] &&
                (wdat[`PSD_ERR_LOCK] || wdat[`PSD_ERR_CLR]);
  assign clr = wr && idx == `PSD_IDX_ERR && PSTRB_I[0] &&
               wdat[`PSD_ERR_CLR];

  // Address decode and read mux; reserved bits read zero
  always_comb begin
    hit = 1'b1;
    rmux = 16'h0000;
    if (PADDR_I[1:0] != 2'h0) begin
      hit = 1'b0; // Unaligned access refused
    end else begin
      unique case (idx)
        `PSD_IDX_STRAP: rmux = {2'h0, state_q.strap};
        `PSD_IDX_BYTE: rmux = state_q.byte_vis;
        `PSD_IDX_ERR: begin
          rmux = {5'h00, state_q.pkt_ovf, state_q.byte_ovf, 1'b0,
                  state_q.err_vis};
        end
        `PSD_IDX_PKTLEN: rmux = state_q.pkt_len;
        `PSD_IDX_DLL: rmux = {6'h00, state_q.dll_ctrl};
        `PSD_IDX_PLL: rmux = state_q.pll;
        `PSD_IDX_FASTDV: rmux = {15'h0000, state_q.fast_dv};
        `PSD_IDX_MODE: rmux = {14'h0000, state_q.mode};
        default: hit = 1'b0; // Unmapped reads zero
      endcase
    end
  end

  // Counter steps; a clear and an event in one cycle keep the event
  assign byte_nx = step(clr ? 16'h0000 : state_q.byte_cnt, `PSD_BYTE_MAX,
                        CHK_EVT_I.byte_rx, cont);
  assign err_nx = step(clr ? 16'h0000 : {8'h00, state_q.err_cnt},
                       `PSD_ERR_MAX, CHK_EVT_I.byte_err, cont);
  assign pkt_nx = step(clr ? 16'h0000 : state_q.pkt_cnt, `PSD_BYTE_MAX,
                       CHK_EVT_I.pkt_done, cont);

  // Next-state logic
  always_comb begin
    state_d = state_q;
    // Strap synchroniser; first stage feeds only the second
    state_d.strap_s1 = STRAP_I;
    state_d.strap_s2 = state_q.strap_s1;
    // Capture once after reset, after two synchroniser stages settle
    if (!state_q.strap_taken) begin
      state_d.strap = state_q.strap_s2;
      state_d.strap_taken = 1'b1;
    end
    // Counters run continuously behind the visible snapshot
    state_d.byte_cnt = byte_nx[15:0];
    state_d.err_cnt = err_nx[7:0];
    state_d.pkt_cnt = pkt_nx[15:0];
    // Snapshot takes values before any clear
    if (lock) begin
      state_d.byte_vis = state_q.byte_cnt;
      state_d.err_vis = state_q.err_cnt;
    end
    // Sticky flags; the clear wins, as a count zeroed by the clear cannot overflow in that cycle
    state_d.pkt_ovf = (state_q.pkt_ovf & ~clr) | pkt_nx[16];
    state_d.byte_ovf = (state_q.byte_ovf & ~clr) | byte_nx[16];
    // Software writes; read-only registers ignore them
    if (wr) begin
      unique case (idx)
        `PSD_IDX_PKTLEN: state_d.pkt_len = merge(state_q.pkt_len, wdat,
                                                 PSTRB_I[1:0]);
        `PSD_IDX_DLL: begin
          state_d.dll_ctrl = 10'(merge({6'h00, state_q.dll_ctrl}, wdat,
                                       PSTRB_I[1:0]));
        end
        `PSD_IDX_PLL: state_d.pll = merge(state_q.pll, wdat, PSTRB_I[1:0]);
        `PSD_IDX_FASTDV: begin
          if (PSTRB_I[0]) begin
            state_d.fast_dv = wdat[0];
          end
        end
        `PSD_IDX_MODE: begin
          if (PSTRB_I[0]) begin
            state_d.mode = wdat[1:0];
          end
        end
        default: ; // Straps and counters are read-only
      endcase
    end
    // Applied DLL enable and delays
    state_d.dly.dll_en = state_q.dll_ctrl[`PSD_DLL_FCTRL] ?
                         state_q.dll_ctrl[`PSD_DLL_FVAL] : DLL_AUTO_EN_I;
    state_d.dly.tx_steps = dsteps(state_q.dll_ctrl[7:4],
                                  state_q.mode[`PSD_MODE_SHIFT]);
    state_d.dly.rx_steps = dsteps(state_q.dll_ctrl[3:0],
                                  state_q.mode[`PSD_MODE_SHIFT]);
    // Read word prepared in the setup cycle, held through access
    if (PSEL_I && !PENABLE_I) begin
      state_d.rdata = rmux;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      state_q <= '0;
      // Synchroniser keeps sampling the pins, so the straps are settled at release
      state_q.strap_s1 <= state_d.strap_s1;
      state_q.strap_s2 <= state_d.strap_s2;
      state_q.pkt_len <= `PSD_RST_PKTLEN;
      state_q.dll_ctrl <= `PSD_RST_DLL;
      state_q.mode <= `PSD_RST_MODE;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs other than PREADY_O and PSLVERR_O, all from flip-flops
  assign PRDATA_O = {16'h0000, state_q.rdata};
  assign STRAP_O = state_q.strap;
  assign TEST_PACKET_LENGTH_O = state_q.pkt_len;
  assign DLY_O = state_q.dly;
  assign PLL_PHASE_SETTING_O = state_q.pll;
  assign EARLY_RECEIVE_VALID_O = state_q.fast_dv;
  assign CNT_CONTINUOUS_O = cont;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);

  // Straps frozen once taken; software cannot move them
  chk_strap_frozen: assert property (
    state_q.strap_taken |=> state_q.strap == $past(state_q.strap))
    else $error("strap value changed after capture");

  // Strap read returns latched bits in place
  chk_strap_read: assert property (
    PSEL_I && !PENABLE_I && PADDR_I == {`PSD_IDX_STRAP, 2'h0}
    |=> PRDATA_O == {18'h00000, $past(state_q.strap)})
    else $error("strap read data wrong");

  // Single mode byte counter stays at maximum
  chk_byte_sat: assert property (
    !cont && !clr && state_q.byte_cnt == `PSD_BYTE_MAX
    |=> state_q.byte_cnt == `PSD_BYTE_MAX &&
        state_q.byte_ovf == ($past(state_q.byte_ovf) || $past(CHK_EVT_I.byte_rx)))
    else $error("byte counter left saturation");

  // Single mode error counter stays at maximum
  chk_err_sat: assert property (
    !cont && !clr && state_q.err_cnt == 8'hFF |=> state_q.err_cnt == 8'hFF)
    else $error("error counter left saturation");

  // Lock snapshots both counters
  chk_lock_snap: assert property (
    lock |=> state_q.byte_vis == $past(state_q.byte_cnt) &&
             state_q.err_vis == $past(state_q.err_cnt))
    else $error("snapshot missed");

  // Clear leaves only the same-cycle event
  chk_clear_cnt: assert property (
    clr |=> state_q.byte_cnt == {15'h0000, $past(CHK_EVT_I.byte_rx)} &&
            state_q.err_cnt == {7'h00, $past(CHK_EVT_I.byte_err)})
    else $error("counters not cleared");

  // Overflow flags hold until clear
  chk_ovf_sticky: assert property (
    (state_q.pkt_ovf || state_q.byte_ovf) && !clr
    |=> $past(state_q.pkt_ovf) <= state_q.pkt_ovf &&
        $past(state_q.byte_ovf) <= state_q.byte_ovf)
    else $error("overflow flag dropped");

  // Reset values after release
  chk_reset_vals: assert property (
    $past(RESET_I) |-> TEST_PACKET_LENGTH_O == `PSD_RST_PKTLEN &&
                       state_q.dll_ctrl == `PSD_RST_DLL)
    else $error("reset value wrong");

  // Forced DLL enable follows value bit
  chk_dll_force: assert property (
    state_q.dll_ctrl[`PSD_DLL_FCTRL] ##1 state_q.dll_ctrl[`PSD_DLL_FCTRL]
    |-> DLY_O.dll_en == $past(state_q.dll_ctrl[`PSD_DLL_FVAL]))
    else $error("forced DLL enable wrong");

  // Receive code 3 with shift gives 1.0 ns
  chk_rx_map: assert property (
    state_q.mode[`PSD_MODE_SHIFT] && state_q.dll_ctrl[3:0] == 4'h3
    |=> DLY_O.rx_steps == 5'h04)
    else $error("receive delay mapping wrong");

  cov_lock: cover property (lock ##[1:20] clr);
  cov_byte_ovf: cover property ($rose(state_q.byte_ovf));
  cov_force: cover property ($rose(DLY_O.dll_en));
  cov_slverr: cover property (PSLVERR_O);
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the strap, PRBS counter and delay registers.
// Assumes psd_top, psd_pkg and psd_regs.svh are compiled alongside.
`timescale 1ns/10ps
`include "psd_regs.svh"
module tb_top;
  import psd_pkg::*;
  // Clock, reset and APB master signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Pins, checker events and settings toward the datapath
  psd_strap_t strap = '0;
  psd_chk_evt_t evt = '0;
  logic auto_en = 1'b0;
  psd_strap_t strap_o;
  logic [15:0] len_o;
  psd_dly_t dly_o;
  logic [15:0] pll_o;
  logic erv_o;
  logic cont_o;
  // Bookkeeping and last bus answer
  int err_total = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic se;
  // Register table walked by the read/write loop
  logic [9:0] ridx [5] = '{`PSD_IDX_PKTLEN, `PSD_IDX_PLL, `PSD_IDX_FASTDV, `PSD_IDX_DLL,
                           `PSD_IDX_MODE};
  logic [31:0] rmsk [5] = '{32'h0000FFFF, 32'h0000FFFF, 32'h00000001, 32'h000003FF,
                            32'h00000003};
  logic [31:0] lastv [5];

  psd_top psd_top_i (
    .REF_CLK_I(clk), .RESET_I(rst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .STRAP_I(strap), .CHK_EVT_I(evt), .DLL_AUTO_EN_I(auto_en),
    .STRAP_O(strap_o), .TEST_PACKET_LENGTH_O(len_o), .DLY_O(dly_o),
    .PLL_PHASE_SETTING_O(pll_o), .EARLY_RECEIVE_VALID_O(erv_o), .CNT_CONTINUOUS_O(cont_o)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // Single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // One APB transfer; waits on pready with no bound of its own
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Wait for ready; only the watchdog ends a stuck transfer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    chk({31'h0, pready}, 32'h1, "ready");
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d, 4'hF);
  endtask

  task automatic chk_rd(input logic [9:0] idx, input logic [31:0] exp, input string msg);
    apb(1'b0, {idx, 2'b00}, 32'h0, 4'hF);
    chk(rd, exp, msg);
  endtask

  // Byte events, the first ne of them errored
  task automatic events(input int nb, input int ne);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      evt <= {1'b1, i < ne, 1'b0};
    end
    @(posedge clk);
    evt <= '0;
  endtask

  // Expected applied delay: code plus one in shift mode, zero for align
  function automatic psd_dly_t dly_exp(input logic [9:0] c, input logic sh, input logic ae);
    psd_dly_t e;
    e.dll_en = c[8] ? c[9] : ae;
    e.tx_steps = (sh && c[7:4] != 4'hF) ? {1'b0, c[7:4]} + 5'h01 : 5'h00;
    e.rx_steps = (sh && c[3:0] != 4'hF) ? {1'b0, c[3:0]} + 5'h01 : 5'h00;
    return e;
  endfunction

  // Verdict and end of run
  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog, beyond the roughly 66k cycles of the whole run
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    final_report();
  end

  // Main sequence
  initial begin
    logic [31:0] v;
    logic [9:0] c;
    int nb, ne, k;
    void'($urandom(32'h034A));
    v = $urandom;
    strap = v[13:0];
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Reset values
    chk_rd(`PSD_IDX_PKTLEN, 32'h05DC, "len rst");
    chk_rd(`PSD_IDX_DLL, 32'h0077, "dll rst");
    chk_rd(`PSD_IDX_BYTE, 32'h0, "byte rst");
    chk_rd(`PSD_IDX_ERR, 32'h0, "err rst");
    chk_rd(`PSD_IDX_FASTDV, 32'h0, "erv rst");
    // Latched straps, raw pin levels, upper bits zero
    chk_rd(`PSD_IDX_STRAP, {18'h0, strap}, "strap");
    chk({18'h0, strap_o}, {18'h0, strap}, "strap out");
    wr_reg(`PSD_IDX_STRAP, 32'hFFFF);
    chk_rd(`PSD_IDX_STRAP, {18'h0, strap}, "strap wr");
    // Random read/write over the writable registers
    for (int i = 0; i < 20; i++) begin
      v = $urandom;
      lastv[i % 5] = v & rmsk[i % 5];
      wr_reg(ridx[i % 5], v);
      chk_rd(ridx[i % 5], lastv[i % 5], "rw");
    end
    chk({16'h0, len_o}, lastv[0], "len out");
    chk({16'h0, pll_o}, lastv[1], "pll out");
    chk({31'h0, erv_o}, lastv[2], "erv out");
    chk({31'h0, cont_o}, {31'h0, lastv[4][0]}, "mode out");
    // Low byte lane only
    apb(1'b1, {`PSD_IDX_PKTLEN, 2'b00}, 32'h0000AB12, 4'h1);
    chk_rd(`PSD_IDX_PKTLEN, {16'h0, lastv[0][15:8], 8'h12}, "lane");
    // Unmapped and unaligned accesses are refused
    apb(1'b1, 12'hFFC, 32'hFFFF, 4'hF);
    chk({31'h0, se}, 32'h1, "unmapped wr");
    apb(1'b0, 12'hFFC, 32'h0, 4'hF);
    chk({rd[31:1], se}, 32'h1, "unmapped rd");
    apb(1'b0, {`PSD_IDX_PLL, 2'b01}, 32'h0, 4'hF);
    chk({31'h0, se}, 32'h1, "unaligned");
    // Counters: lock, hold, lock and clear
    wr_reg(`PSD_IDX_MODE, 32'h2);
    nb = $urandom_range(20, 1);
    ne = $urandom_range(nb, 0);
    events(nb, ne);
    wr_reg(`PSD_IDX_ERR, 32'h1);
    chk_rd(`PSD_IDX_BYTE, nb, "byte lock");
    chk_rd(`PSD_IDX_ERR, ne, "err lock");
    wr_reg(`PSD_IDX_BYTE, 32'hFFFF);
    k = $urandom_range(9, 1);
    events(k, 0);
    chk_rd(`PSD_IDX_BYTE, nb, "byte held");
    wr_reg(`PSD_IDX_ERR, 32'h2);
    chk_rd(`PSD_IDX_BYTE, nb + k, "byte clr snap");
    wr_reg(`PSD_IDX_ERR, 32'h1);
    chk_rd(`PSD_IDX_BYTE, 32'h0, "byte cleared");
    chk_rd(`PSD_IDX_ERR, 32'h0, "err cleared");
    // Continuous mode: errored byte counter wraps past 0xFF
    wr_reg(`PSD_IDX_MODE, 32'h3);
    events(260, 260);
    wr_reg(`PSD_IDX_ERR, 32'h2);
    chk_rd(`PSD_IDX_ERR, 32'h0004, "err wrap");
    chk_rd(`PSD_IDX_BYTE, 32'h0104, "byte cont");
    // Every receive delay code, forced and automatic enable, shift on then off
    for (int i = 0; i < 32; i++) begin
      if (i % 16 == 0) wr_reg(`PSD_IDX_MODE, (i < 16) ? 32'h2 : 32'h0);
      v = $urandom;
      c = {v[9:4], i[3:0]};
      @(posedge clk);
      auto_en <= v[10];
      wr_reg(`PSD_IDX_DLL, {22'h0, c});
      repeat (2) @(posedge clk);
      #1;
      chk({21'h0, dly_o}, {21'h0, dly_exp(c, i < 16, v[10])}, "dly");
    end
    // Single mode saturation and sticky packet overflow
    @(posedge clk);
    evt <= 3'b111;
    repeat (65540) @(posedge clk);
    evt <= '0;
    wr_reg(`PSD_IDX_ERR, 32'h1);
    chk_rd(`PSD_IDX_BYTE, 32'hFFFF, "byte sat");
    apb(1'b0, {`PSD_IDX_ERR, 2'b00}, 32'h0, 4'hF);
    chk(rd, 32'h06FF, "err sat");
    wr_reg(`PSD_IDX_ERR, 32'h2);
    wr_reg(`PSD_IDX_ERR, 32'h1);
    chk_rd(`PSD_IDX_ERR, 32'h0, "ovf cleared");
    final_report();
  end
endmodule
